// [rtl/power_handshake_pkg.sv]
// Purpose: shared constants for the module power handshake
// Assumes: 100 MHz reference clock
// Notes:   times kept in ns, cycle counts derived
package power_handshake_pkg;
    // ========================================
    // timing
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned OFF_MIN_NS      = 10_000;
    localparam int unsigned OFF_MIN_CYCLES  =
        (OFF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RESET_HOLD_NS   = 1_000;
    localparam int unsigned RESET_HOLD_CYCLES =
        (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned COUNT_W         = 16;
    localparam int unsigned SYNC_STAGES     = 2;
    localparam int unsigned WAKE_SOURCES    = 4;
    // ========================================
    // wake source bit positions
    localparam int unsigned WAKE_SPI_BIT    = 0;
    localparam int unsigned WAKE_I2C_BIT    = 1;
    localparam int unsigned WAKE_RTC_BIT    = 2;
    localparam int unsigned WAKE_USB_BIT    = 3;
    // ========================================
    // reset values of pins
    localparam logic RELEASED_LVL           = 1'b1;
    localparam logic ASSERTED_LVL           = 1'b0;
endpackage

// [rtl/power_link_if.sv]
// Purpose: board-level pins between module and carrier
// Assumes: open-drain lines resolved here from enables
// Notes:   pull-ups modelled as released high
`timescale 1ns/100ps
interface power_link_if;
    logic power_on;
    logic suspend_toggle;
    logic recovery_strap_n;
    logic system_reset_n_oe;
    logic shutdown_req_n_oe;
    logic module_asleep_n;
    logic carrier_type_strap;
    logic system_reset_n;
    logic shutdown_req_n;

    // ========================================
    // open-drain resolution
    assign system_reset_n = system_reset_n_oe ? 1'b0 : 1'b1;
    assign shutdown_req_n = shutdown_req_n_oe ? 1'b0 : 1'b1;

    modport module_end
    (
        input  power_on,
        input  suspend_toggle,
        input  recovery_strap_n,
        input  system_reset_n,
        output system_reset_n_oe,
        output shutdown_req_n_oe,
        output module_asleep_n,
        output carrier_type_strap
    );
    modport carrier_end
    (
        output power_on,
        output suspend_toggle,
        output recovery_strap_n,
        input  system_reset_n,
        input  shutdown_req_n,
        input  module_asleep_n,
        input  carrier_type_strap
    );
endinterface

// [rtl/module_power_handshake.sv]
// Purpose: module end of the power handshake
// Assumes: single 100 MHz clock, pins asynchronous
// Notes:   system reset held a short time before release
`timescale 1ns/100ps
module module_power_handshake #(
    parameter int unsigned OFF_MIN_CYCLES =
        power_handshake_pkg::OFF_MIN_CYCLES,
    parameter int unsigned HOLD_CYCLES    =
        power_handshake_pkg::RESET_HOLD_CYCLES,
    parameter logic        LEGACY_MODULE  = 1'b0
)
(
    input  wire logic                    ref_clk_in,
    input  wire logic                    sys_rst_in,
    power_link_if.module_end             link,
    input  wire logic                    sw_shutdown_in,
    input  wire logic                    thermal_shutdown_in,
    input  wire logic                    sleep_enter_in,
    input  wire logic [power_handshake_pkg::WAKE_SOURCES-1:0]
                                         wake_event_in,
    output logic                         cpu_reset_out,
    output logic                         storage_reset_out,
    output logic                         recovery_boot_out,
    output logic                         deep_sleep_out,
    output logic                         shutdown_done_out
);
    typedef enum logic [2:0] {
        ST_OFF,
        ST_HOLD,
        ST_ON,
        ST_SLEEP,
        ST_SHUTDOWN
    } state_type;

    localparam int unsigned CW = power_handshake_pkg::COUNT_W;

    state_type   state_q;
    logic [1:0]  pwr_sync_q;
    logic [1:0]  sus_sync_q;
    logic [1:0]  rec_sync_q;
    logic [1:0]  rst_sync_q;
    logic        sus_prev_q;
    logic        rst_prev_q;
    logic [CW-1:0] count_q;
    logic        shut_req_q;
    logic        sus_edge;
    logic        rst_rise;
    logic        off_long;
    logic        any_wake;

    // ========================================
    // input synchronisers
    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            pwr_sync_q <= 2'b00;
            sus_sync_q <= 2'b11;
            rec_sync_q <= 2'b11;
            rst_sync_q <= 2'b00;
        end
        else
        begin
            pwr_sync_q <= {pwr_sync_q[0], link.power_on};
            sus_sync_q <= {sus_sync_q[0], link.suspend_toggle};
            rec_sync_q <= {rec_sync_q[0], link.recovery_strap_n};
            rst_sync_q <= {rst_sync_q[0], link.system_reset_n};
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            sus_prev_q <= 1'b1;
            rst_prev_q <= 1'b0;
        end
        else
        begin
            sus_prev_q <= sus_sync_q[1];
            rst_prev_q <= rst_sync_q[1];
        end
    end

    assign sus_edge = sus_prev_q != sus_sync_q[1];
    assign rst_rise = rst_sync_q[1] && !rst_prev_q;
    assign any_wake = |wake_event_in;
    assign off_long = !pwr_sync_q[1]
        && count_q >= CW'(OFF_MIN_CYCLES);

    // ========================================
    // power-on low time and reset hold counter
    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            count_q <= '0;
        else if (state_q == ST_HOLD)
            count_q <= (count_q == CW'(HOLD_CYCLES)) ? count_q
                : count_q + CW'(1);
        else if (pwr_sync_q[1])
            count_q <= '0;
        else if (count_q < CW'(OFF_MIN_CYCLES))
            count_q <= count_q + CW'(1);
    end

    // ========================================
    // power state machine
    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            state_q <= ST_OFF;
        else
        begin
            case (state_q)
                ST_OFF:
                    if (pwr_sync_q[1])
                        state_q <= ST_HOLD;
                ST_HOLD:
                    if (!pwr_sync_q[1])
                        state_q <= ST_OFF;
                    else if (count_q == CW'(HOLD_CYCLES))
                        state_q <= ST_ON;
                ST_ON:
                    if (!pwr_sync_q[1])
                        state_q <= ST_SHUTDOWN;
                    else if (sleep_enter_in || sus_edge)
                        state_q <= ST_SLEEP;
                ST_SLEEP:
                    if (!pwr_sync_q[1])
                        state_q <= ST_SHUTDOWN;
                    else if (any_wake || sus_edge)
                        state_q <= ST_ON;
                ST_SHUTDOWN:
                    if (off_long)
                        state_q <= ST_OFF;
                    else if (pwr_sync_q[1])
                        state_q <= ST_HOLD;
                default:
                    state_q <= ST_OFF;
            endcase
        end
    end

    // ========================================
    // shutdown request, held until power-on drops
    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            shut_req_q <= 1'b0;
        else if (sw_shutdown_in || thermal_shutdown_in)
            shut_req_q <= 1'b1;
        else if (!pwr_sync_q[1])
            shut_req_q <= 1'b0;
    end

    // ========================================
    // pin and user outputs
    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            link.system_reset_n_oe <= 1'b1;
            link.shutdown_req_n_oe <= 1'b0;
            link.module_asleep_n   <= power_handshake_pkg::RELEASED_LVL;
            link.carrier_type_strap <= 1'b1;
            cpu_reset_out          <= 1'b1;
            storage_reset_out      <= 1'b1;
            deep_sleep_out         <= 1'b0;
            shutdown_done_out      <= 1'b0;
        end
        else
        begin
            link.system_reset_n_oe <= !(state_q == ST_ON
                || state_q == ST_SLEEP);
            link.shutdown_req_n_oe <= shut_req_q;
            link.module_asleep_n   <= state_q != ST_SLEEP;
            link.carrier_type_strap <= !LEGACY_MODULE;
            cpu_reset_out          <= !rst_sync_q[1];
            storage_reset_out      <= !rst_sync_q[1];
            deep_sleep_out         <= state_q == ST_SLEEP;
            shutdown_done_out      <= state_q == ST_OFF;
        end
    end

    // ========================================
    // recovery strap capture on reset release
    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            recovery_boot_out <= 1'b0;
        else if (rst_rise)
            recovery_boot_out <= !rec_sync_q[1];
    end
endmodule

// [rtl/carrier_power_handshake.sv]
// Purpose: carrier end of the power handshake
// Assumes: single 100 MHz clock, module pins asynchronous
// Notes:   power-on follows supply good and the shutdown line
`timescale 1ns/100ps
module carrier_power_handshake
(
    input  wire logic        ref_clk_in,
    input  wire logic        sys_rst_in,
    power_link_if.carrier_end link,
    input  wire logic        supply_good_in,
    input  wire logic        want_recovery_in,
    input  wire logic        sleep_toggle_in,
    output logic             carrier_power_en_out,
    output logic             legacy_module_out,
    output logic             module_sleeping_out
);
    logic [1:0] rst_sync_q;
    logic [1:0] shut_sync_q;
    logic [1:0] sleep_sync_q;
    logic [1:0] type_sync_q;

    // ========================================
    // input synchronisers
    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            rst_sync_q   <= 2'b00;
            shut_sync_q  <= 2'b11;
            sleep_sync_q <= 2'b11;
            type_sync_q  <= 2'b11;
        end
        else
        begin
            rst_sync_q   <= {rst_sync_q[0], link.system_reset_n};
            shut_sync_q  <= {shut_sync_q[0], link.shutdown_req_n};
            sleep_sync_q <= {sleep_sync_q[0], link.module_asleep_n};
            type_sync_q  <= {type_sync_q[0], link.carrier_type_strap};
        end
    end

    // ========================================
    // pin drive and status
    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            link.power_on         <= 1'b0;
            link.suspend_toggle   <= 1'b1;
            link.recovery_strap_n <= 1'b1;
            carrier_power_en_out  <= 1'b0;
            legacy_module_out     <= 1'b0;
            module_sleeping_out   <= 1'b0;
        end
        else
        begin
            link.power_on <= supply_good_in && shut_sync_q[1];
            link.suspend_toggle <= link.suspend_toggle
                ^ sleep_toggle_in;
            link.recovery_strap_n <= !want_recovery_in;
            carrier_power_en_out <= rst_sync_q[1]
                && link.power_on;
            legacy_module_out   <= !type_sync_q[1];
            module_sleeping_out <= !sleep_sync_q[1];
        end
    end
endmodule

// [bench/power_handshake_sva.sv]
// Purpose: pin-level checks of the power handshake
// Assumes: bench counts, hold 4, off minimum 8
// Notes:   watches the interface signals only
`timescale 1ns/100ps
module power_handshake_sva
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic power_on_in,
    input wire logic suspend_toggle_in,
    input wire logic module_asleep_n_in,
    input wire logic carrier_type_strap_in,
    input wire logic system_reset_n_in,
    input wire logic shutdown_req_n_in
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (sys_rst_in);
    // ========================================
    // sequences
    sequence s_off;
        $fell(power_on_in) ##1 !power_on_in [*5];
    endsequence
    sequence s_on;
        $rose(power_on_in) ##1 power_on_in [*8];
    endsequence
    sequence s_toggle_on;
        $changed(suspend_toggle_in) ##0
            (system_reset_n_in && power_on_in && module_asleep_n_in);
    endsequence
    // ========================================
    // properties
    property p_strap;
        carrier_type_strap_in;
    endproperty
    property p_off;
        s_off |-> !system_reset_n_in;
    endproperty
    property p_gate;
        $rose(system_reset_n_in) |-> power_on_in && $past(power_on_in, 4);
    endproperty
    property p_release;
        s_on |-> ##[1:8] system_reset_n_in;
    endproperty
    property p_drop;
        $fell(shutdown_req_n_in) |-> ##[1:6] !power_on_in;
    endproperty
    property p_sleep_src;
        $fell(module_asleep_n_in) |-> system_reset_n_in && power_on_in;
    endproperty
    property p_enter;
        s_toggle_on |-> ##[2:8] !module_asleep_n_in;
    endproperty
    property p_exit;
        $changed(suspend_toggle_in) && !module_asleep_n_in
            |-> ##[2:8] module_asleep_n_in;
    endproperty
    a_strap: assert property (p_strap)
        else $error("strap not high");
    a_off: assert property (p_off)
        else $error("reset not asserted after power off");
    a_gate: assert property (p_gate)
        else $error("reset released without power on");
    a_release: assert property (p_release)
        else $error("reset not released after power on");
    a_drop: assert property (p_drop)
        else $error("power on not dropped on request");
    a_sleep_src: assert property (p_sleep_src)
        else $error("sleep entered outside on state");
    a_enter: assert property (p_enter)
        else $error("toggle did not enter sleep");
    a_exit: assert property (p_exit)
        else $error("toggle did not leave sleep");
endmodule

// [bench/module_power_handshake_bench.sv]
// Purpose: module and carrier ends joined and driven
// Assumes: small counts, hold 4 and off minimum 8
// Notes:   inputs change on the falling edge
`timescale 1ns/100ps
module module_power_handshake_bench;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       sw = 1'b0;
    logic       th = 1'b0;
    logic       se = 1'b0;
    logic [3:0] wake = 4'h0;
    logic       good = 1'b0;
    logic       rec = 1'b0;
    logic       tog = 1'b0;
    logic       cpu_rst, sto_rst, rec_boot, dsleep, done;
    logic       pwr_en, legacy, sleeping;
    int         num_errors = 0;
    int         check_count = 0;
    // ========================================
    // ends and checker
    power_link_if link ();
    module_power_handshake #(.OFF_MIN_CYCLES(8), .HOLD_CYCLES(4))
    i_module_power_handshake
    (
        .ref_clk_in(clk), .sys_rst_in(rst), .link(link),
        .sw_shutdown_in(sw), .thermal_shutdown_in(th),
        .sleep_enter_in(se), .wake_event_in(wake),
        .cpu_reset_out(cpu_rst), .storage_reset_out(sto_rst),
        .recovery_boot_out(rec_boot), .deep_sleep_out(dsleep),
        .shutdown_done_out(done)
    );
    carrier_power_handshake i_carrier_power_handshake
    (
        .ref_clk_in(clk), .sys_rst_in(rst), .link(link),
        .supply_good_in(good), .want_recovery_in(rec),
        .sleep_toggle_in(tog), .carrier_power_en_out(pwr_en),
        .legacy_module_out(legacy), .module_sleeping_out(sleeping)
    );
    power_handshake_sva i_power_handshake_sva
    (
        .ref_clk_in(clk), .sys_rst_in(rst),
        .power_on_in(link.power_on),
        .suspend_toggle_in(link.suspend_toggle),
        .module_asleep_n_in(link.module_asleep_n),
        .carrier_type_strap_in(link.carrier_type_strap),
        .system_reset_n_in(link.system_reset_n),
        .shutdown_req_n_in(link.shutdown_req_n)
    );
    always #5 clk = ~clk;
    // ========================================
    // helpers
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic hold(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ========================================
    // scenarios
    task automatic power_up(input logic r);
        rec = r;
        good = 1'b1;
        hold(3);
        check({link.system_reset_n, pwr_en, cpu_rst, sto_rst}, 4'h3);
        for (int i = 0; i < 40 && link.system_reset_n !== 1'b1; i++)
            hold(1);
        hold(5);
        check({link.system_reset_n, pwr_en, cpu_rst, sto_rst}, 4'hc);
        check(rec_boot, r);
        check({done, legacy, link.shutdown_req_n}, 4'h1);
    endtask
    task automatic sleep_wake(input int b);
        se = 1'b1;
        hold(1);
        se = 1'b0;
        hold(8);
        check({dsleep, link.module_asleep_n, sleeping}, 4'h5);
        wake[b] = 1'b1;
        hold(2);
        wake[b] = 1'b0;
        hold(8);
        check({dsleep, link.module_asleep_n, sleeping}, 4'h2);
    endtask
    task automatic toggle_twice();
        for (int k = 0; k < 2; k++)
        begin
            tog = 1'b1;
            hold(1);
            tog = 1'b0;
            hold(12);
            check({dsleep, link.module_asleep_n}, {k == 0, k != 0});
        end
    endtask
    task automatic hw_off();
        good = 1'b0;
        hold(9);
        check({link.system_reset_n, cpu_rst, sto_rst, done}, 4'h6);
        hold(10);
        check({link.power_on, done}, 4'h1);
    endtask
    task automatic shut_req(input logic thermal);
        th = thermal;
        sw = !thermal;
        hold(1);
        th = 1'b0;
        sw = 1'b0;
        hold(2);
        check(link.shutdown_req_n, 4'h0);
        good = 1'b0;
        hold(10);
        check({link.power_on, link.system_reset_n, pwr_en}, 4'h0);
        hold(12);
        check({done, link.shutdown_req_n}, 4'h3);
    endtask
    task automatic power_glitch();
        good = 1'b0;
        hold(3);
        good = 1'b1;
        hold(4);
        check({link.system_reset_n, done}, 4'h0);
        hold(12);
        check({link.system_reset_n, cpu_rst, done, pwr_en}, 4'h9);
    endtask
    task automatic sleep_off();
        se = 1'b1;
        hold(1);
        se = 1'b0;
        hold(8);
        check({dsleep, link.module_asleep_n}, 4'h2);
        good = 1'b0;
        hold(20);
        check({dsleep, link.module_asleep_n}, 4'h1);
        check({link.system_reset_n, done}, 4'h1);
        tog = 1'b1;
        wake = 4'h1;
        hold(1);
        tog = 1'b0;
        wake = 4'h0;
        hold(12);
        check({dsleep, link.module_asleep_n, done, sleeping}, 4'h6);
    endtask
    // ========================================
    // main sequence and watchdog
    initial
    begin
        hold(3);
        rst = 1'b0;
        check({link.system_reset_n, link.shutdown_req_n}, 4'h1);
        check({link.module_asleep_n, link.carrier_type_strap}, 4'h3);
        power_up(1'b0);
        for (int b = 0; b < 4; b++)
            sleep_wake(b);
        toggle_twice();
        power_glitch();
        hw_off();
        power_up(1'b1);
        shut_req(1'b0);
        power_up(1'b0);
        sleep_off();
        power_up(1'b0);
        shut_req(1'b1);
        stop_test();
    end
    initial
    begin
        #20000;
        num_errors++;
        stop_test();
    end
endmodule
